// ### rtl/dacpf_consts.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef DACPF_CONSTS_SVH
`define DACPF_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define DACPF_OFF_DAC_A 8'h00
`define DACPF_OFF_DAC_B 8'h04
`define DACPF_OFF_PWR 8'h08
`define DACPF_OFF_CTRL 8'h0C
`define DACPF_OFF_IRQ_STAT 8'h10
`define DACPF_OFF_IRQ_EN 8'h14
`define DACPF_OFF_IRQ_CLR 8'h18
`define DACPF_OFF_READY 8'h1C

// ****************************************************************
// register select field values
// ****************************************************************
`define DACPF_SEL_DAC 3'h0
`define DACPF_SEL_PWR 3'h2
`define DACPF_SEL_CTRL 3'h3

// ****************************************************************
// power control fields
// ****************************************************************
`define DACPF_PWR_PU_A 0
`define DACPF_PWR_PU_B 2
`define DACPF_PWR_TALERT 5
`define DACPF_PWR_OC_A 7
`define DACPF_PWR_OC_B 9

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define DACPF_CTRL_CLAMP 2
`define DACPF_CTRL_TSD 3
`define DACPF_CTRL_CLAMP_RST 1'h1
`define DACPF_CTRL_TSD_RST 1'h0

// ****************************************************************
// interrupt bits
// ****************************************************************
`define DACPF_IRQ_OC_A 0
`define DACPF_IRQ_OC_B 1
`define DACPF_IRQ_THERM 2
`define DACPF_IRQ_W 3

// ****************************************************************
// timing
// ****************************************************************
`define DACPF_CLK_NS 20
`define DACPF_PU_TIME_NS 10000
`define DACPF_PU_CYC ((`DACPF_PU_TIME_NS + `DACPF_CLK_NS - 1) / `DACPF_CLK_NS)

`endif

// ### rtl/dacpf_pkg.sv
// types shared by the power and fault control block
package dacpf_pkg;

	typedef enum logic [1:0] {
		DACPF_CH_OFF = 2'b00,
		DACPF_CH_WAKING = 2'b01,
		DACPF_CH_READY = 2'b10
	} dacpf_ch_state_t;

	typedef logic [31:0] dacpf_word_t;

endpackage

// ### rtl/dacpf_sync.sv
// two flip-flop synchroniser for fault monitor levels
`timescale 1ns/10ps
module dacpf_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end

	assign q_o = q_r;

endmodule

// ### rtl/dacpf_chan.sv
// one converter channel: power bit, fault response and output gates
`timescale 1ns/10ps
module dacpf_chan
	import dacpf_pkg::*;
#(
	parameter int PU_CYC = 500
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// host control
	input wire logic pu_wr_i,
	input wire logic pu_wdata_i,
	input wire logic clamp_en_i,
	input wire logic valid_i,
	// synchronised faults
	input wire logic oc_i,
	input wire logic therm_trip_i,
	// status
	output logic power_on_o,
	output logic oc_flag_o,
	output logic oc_rise_o,
	output logic ready_o,
	// output stage
	output logic amp_gate_o,
	output logic gnd_gate_o
);

	localparam int CW = $clog2(PU_CYC + 1);
	localparam logic [CW-1:0] CNT_END = CW'(PU_CYC);

	logic pu_r;
	logic oc_r;
	logic amp_r;
	logic [CW-1:0] cnt_r;
	dacpf_ch_state_t st_r;
	dacpf_ch_state_t st_nxt;

	wire auto_off = oc_i & ~clamp_en_i;
	wire fault_off = auto_off | therm_trip_i;
	// fault power-down wins over a host write in the same cycle
	wire pu_nxt = fault_off ? 1'b0 : (pu_wr_i ? pu_wdata_i : pu_r);
	wire amp_nxt = pu_nxt & valid_i & ~fault_off;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			DACPF_CH_OFF: if (pu_r) st_nxt = DACPF_CH_WAKING;
			DACPF_CH_WAKING: begin
				if (!pu_r)
					st_nxt = DACPF_CH_OFF;
				else if (cnt_r == CNT_END)
					st_nxt = DACPF_CH_READY;
			end
			DACPF_CH_READY: if (!pu_r) st_nxt = DACPF_CH_OFF;
			default: st_nxt = DACPF_CH_OFF;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pu_r <= 1'b0;
			oc_r <= 1'b0;
			amp_r <= 1'b0;
			cnt_r <= '0;
			st_r <= DACPF_CH_OFF;
		end else begin
			pu_r <= pu_nxt;
			oc_r <= oc_i;
			amp_r <= amp_nxt;
			st_r <= st_nxt;
			cnt_r <= (st_r == DACPF_CH_WAKING) ? cnt_r + 1'b1 : '0;
		end
	end

	assign power_on_o = pu_r;
	assign oc_flag_o = oc_r;
	assign oc_rise_o = oc_i & ~oc_r;
	assign ready_o = (st_r == DACPF_CH_READY);
	assign amp_gate_o = amp_r;
	assign gnd_gate_o = ~amp_r;

endmodule

// ### rtl/dacpf_top.sv
// power and fault supervision for a two-channel converter, APB slave
//
// What this block does
// - outputs stay isolated and grounded until supplies are good and a converter word has been written.
// - each channel powers up or down from its own power-on bit.
// - after reset both channels are powered down with the output grounded.
// - the clamp-enable bit chooses clamping or automatic power-down on overcurrent.
// - with clamp enabled a shorted channel keeps running under current limit.
// - in clamp mode the overcurrent flag follows the short and clears when it goes.
// - with clamp disabled a short powers the channel down and grounds its output.
// - in power-down mode the short sets the flag and clears the channel power-on bit.
// - thermal shutdown is off after reset and only the host enable turns it on.
// - an enabled over-temperature shuts down both channels and sets the thermal alert.
// - power control sits at select 010 with bits 0, 2, 5, 7 and 9 as laid out.
// - thermal enable is control bit 3 (reset 0), clamp enable bit 2 (reset 1).
`timescale 1ns/10ps
`include "dacpf_consts.svh"
module dacpf_top
	import dacpf_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int PU_CYC = `DACPF_PU_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// analog monitors
	input wire logic supply_ok_i,
	input wire logic oc_a_i,
	input wire logic oc_b_i,
	input wire logic over_temp_i,
	// converter data
	output logic [DATA_W-1:0] dac_a_data_o,
	output logic [DATA_W-1:0] dac_b_data_o,
	// output stage control
	output logic [1:0] amp_output_gate_o,
	output logic [1:0] output_ground_clamp_gate_o,
	output logic current_clamp_en_o,
	// interrupt
	output logic irq_o
);

	// ****************************************************************
	// bus decode
	// ****************************************************************

	wire setup = psel_i & ~penable_i;
	wire access = psel_i & penable_i;
	wire wr = access & pwrite_i;

	wire sel_dac_a = (paddr_i == `DACPF_OFF_DAC_A);
	wire sel_dac_b = (paddr_i == `DACPF_OFF_DAC_B);
	wire sel_pwr = (paddr_i == `DACPF_OFF_PWR);
	wire sel_ctrl = (paddr_i == `DACPF_OFF_CTRL);
	wire sel_stat = (paddr_i == `DACPF_OFF_IRQ_STAT);
	wire sel_en = (paddr_i == `DACPF_OFF_IRQ_EN);
	wire sel_clr = (paddr_i == `DACPF_OFF_IRQ_CLR);
	wire sel_rdy = (paddr_i == `DACPF_OFF_READY);

	wire mapped = sel_dac_a | sel_dac_b | sel_pwr | sel_ctrl | sel_stat
		| sel_en | sel_clr | sel_rdy;

	wire wr_dac_a = wr & sel_dac_a;
	wire wr_dac_b = wr & sel_dac_b;
	wire wr_pwr = wr & sel_pwr;
	wire wr_ctrl = wr & sel_ctrl;
	wire wr_en = wr & sel_en;
	wire wr_clr = wr & sel_clr;
	wire dac_wr = wr_dac_a | wr_dac_b;
	wire rd_setup = setup & ~pwrite_i;

	// ****************************************************************
	// bus response
	// ****************************************************************

	// zero wait states; unmapped addresses answer with an error
	assign pready_o = 1'b1;
	assign pslverr_o = access & ~mapped;

	// ****************************************************************
	// write data fields
	// ****************************************************************

	wire wd_pu_a = pwdata_i[`DACPF_PWR_PU_A];
	wire wd_pu_b = pwdata_i[`DACPF_PWR_PU_B];
	wire wd_clamp = pwdata_i[`DACPF_CTRL_CLAMP];
	wire wd_tsd = pwdata_i[`DACPF_CTRL_TSD];
	wire [`DACPF_IRQ_W-1:0] wd_irq = pwdata_i[`DACPF_IRQ_W-1:0];
	wire [DATA_W-1:0] wd_dac = pwdata_i[DATA_W-1:0];

	// ****************************************************************
	// fault monitor synchronisers
	// ****************************************************************

	logic [2:0] mon_sync;

	dacpf_sync #(
		.W(3)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({over_temp_i, oc_b_i, oc_a_i}),
		.q_o(mon_sync)
	);

	wire oc_a_s = mon_sync[0];
	wire oc_b_s = mon_sync[1];
	wire ot_s = mon_sync[2];

	// ****************************************************************
	// control register
	// ****************************************************************

	logic clamp_en_r;
	logic tsd_en_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			clamp_en_r <= `DACPF_CTRL_CLAMP_RST;
		else if (wr_ctrl)
			clamp_en_r <= wd_clamp;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			tsd_en_r <= `DACPF_CTRL_TSD_RST;
		else if (wr_ctrl)
			tsd_en_r <= wd_tsd;
	end

	// ****************************************************************
	// current limit
	// ****************************************************************

	// the output stage limits current while the clamp bit is set
	assign current_clamp_en_o = clamp_en_r;

	// ****************************************************************
	// thermal shutdown
	// ****************************************************************

	// only an enabled monitor may trip both channels
	wire therm_trip = tsd_en_r & ot_s;

	logic talert_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			talert_r <= 1'b0;
		else
			talert_r <= therm_trip;
	end

	// ****************************************************************
	// converter data and first valid write
	// ****************************************************************

	logic [DATA_W-1:0] dac_a_r;
	logic [DATA_W-1:0] dac_b_r;
	logic valid_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			dac_a_r <= '0;
		else if (wr_dac_a)
			dac_a_r <= wd_dac;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			dac_b_r <= '0;
		else if (wr_dac_b)
			dac_b_r <= wd_dac;
	end

	// a supply drop re-arms isolation until the next valid word
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			valid_r <= 1'b0;
		else if (!supply_ok_i)
			valid_r <= 1'b0;
		else if (dac_wr)
			valid_r <= 1'b1;
	end

	assign dac_a_data_o = dac_a_r;
	assign dac_b_data_o = dac_b_r;

	wire valid_now = valid_r & supply_ok_i;

	// ****************************************************************
	// channels
	// ****************************************************************

	logic pu_a;
	logic pu_b;
	logic oc_a_flag;
	logic oc_b_flag;
	logic oc_a_rise;
	logic oc_b_rise;
	logic rdy_a;
	logic rdy_b;

	// the fault flags are not writable; only power bits take data
	dacpf_chan #(
		.PU_CYC(PU_CYC)
	) u_chan_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pu_wr_i(wr_pwr),
		.pu_wdata_i(wd_pu_a),
		.clamp_en_i(clamp_en_r),
		.valid_i(valid_now),
		.oc_i(oc_a_s),
		.therm_trip_i(therm_trip),
		.power_on_o(pu_a),
		.oc_flag_o(oc_a_flag),
		.oc_rise_o(oc_a_rise),
		.ready_o(rdy_a),
		.amp_gate_o(amp_output_gate_o[0]),
		.gnd_gate_o(output_ground_clamp_gate_o[0])
	);

	dacpf_chan #(
		.PU_CYC(PU_CYC)
	) u_chan_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pu_wr_i(wr_pwr),
		.pu_wdata_i(wd_pu_b),
		.clamp_en_i(clamp_en_r),
		.valid_i(valid_now),
		.oc_i(oc_b_s),
		.therm_trip_i(therm_trip),
		.power_on_o(pu_b),
		.oc_flag_o(oc_b_flag),
		.oc_rise_o(oc_b_rise),
		.ready_o(rdy_b),
		.amp_gate_o(amp_output_gate_o[1]),
		.gnd_gate_o(output_ground_clamp_gate_o[1])
	);

	// ****************************************************************
	// interrupts
	// ****************************************************************

	logic [`DACPF_IRQ_W-1:0] irq_stat_r;
	logic [`DACPF_IRQ_W-1:0] irq_en_r;
	logic [`DACPF_IRQ_W-1:0] irq_ev;
	logic [`DACPF_IRQ_W-1:0] irq_clr;
	logic therm_prev_r;

	assign irq_ev[`DACPF_IRQ_OC_A] = oc_a_rise;
	assign irq_ev[`DACPF_IRQ_OC_B] = oc_b_rise;
	assign irq_ev[`DACPF_IRQ_THERM] = therm_trip & ~therm_prev_r;
	assign irq_clr = wr_clr ? wd_irq : '0;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			therm_prev_r <= 1'b0;
		else
			therm_prev_r <= therm_trip;
	end

	// a new event outranks a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			irq_en_r <= '0;
		else if (wr_en)
			irq_en_r <= wd_irq;
	end

	wire [`DACPF_IRQ_W-1:0] irq_pend = irq_stat_r & irq_en_r;
	assign irq_o = |irq_pend;

	// ****************************************************************
	// read back
	// ****************************************************************

	dacpf_word_t rd_pwr;
	dacpf_word_t rd_ctrl;
	dacpf_word_t rd_mux;
	dacpf_word_t prdata_r;

	always_comb begin
		rd_pwr = '0;
		rd_pwr[`DACPF_PWR_PU_A] = pu_a;
		rd_pwr[`DACPF_PWR_PU_B] = pu_b;
		rd_pwr[`DACPF_PWR_TALERT] = talert_r;
		rd_pwr[`DACPF_PWR_OC_A] = oc_a_flag;
		rd_pwr[`DACPF_PWR_OC_B] = oc_b_flag;
	end

	always_comb begin
		rd_ctrl = '0;
		rd_ctrl[`DACPF_CTRL_CLAMP] = clamp_en_r;
		rd_ctrl[`DACPF_CTRL_TSD] = tsd_en_r;
	end

	always_comb begin
		if (sel_dac_a)
			rd_mux = 32'(dac_a_r);
		else if (sel_dac_b)
			rd_mux = 32'(dac_b_r);
		else if (sel_pwr)
			rd_mux = rd_pwr;
		else if (sel_ctrl)
			rd_mux = rd_ctrl;
		else if (sel_stat)
			rd_mux = 32'(irq_stat_r);
		else if (sel_en)
			rd_mux = 32'(irq_en_r);
		else if (sel_rdy)
			rd_mux = {30'h0, rdy_b, rdy_a};
		else
			rd_mux = 32'h0;
	end

	// read data is captured in the setup cycle and held for the access
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			prdata_r <= '0;
		else if (rd_setup)
			prdata_r <= rd_mux;
	end

	assign prdata_o = prdata_r;

endmodule

// ### test/dacpf_top_properties.sv
// port assertions for the power and fault block
`timescale 1ns/10ps
`include "dacpf_consts.svh"
module dacpf_top_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// inputs watched
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic supply_ok_i,
	input wire logic oc_a_i,
	// outputs watched
	input wire logic [1:0] amp_output_gate_o,
	input wire logic [1:0] output_ground_clamp_gate_o,
	input wire logic current_clamp_en_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire wr_ok = psel_i && penable_i && pwrite_i;
	wire clamp_bit = pwdata_i[`DACPF_CTRL_CLAMP];
	wire pu_a_bit = pwdata_i[`DACPF_PWR_PU_A];
	a_gate_exclusive: assert property (
		output_ground_clamp_gate_o == ~amp_output_gate_o)
		else $error("ground and amp gates overlap");
	a_reset_isolated: assert property (
		$fell(rst_i) |-> (amp_output_gate_o == 2'h0) [*3])
		else $error("output connected right after reset");
	a_clamp_default: assert property (
		$fell(rst_i) |-> current_clamp_en_o)
		else $error("clamp not enabled after reset");
	a_supply_iso: assert property (
		!supply_ok_i ##1 !supply_ok_i |-> amp_output_gate_o == 2'h0)
		else $error("output connected without supply");
	a_gate_needs_supply: assert property (
		$rose(amp_output_gate_o[0]) |-> $past(supply_ok_i))
		else $error("channel a connected without supply");
	a_clamp_write: assert property (
		wr_ok && paddr_i == `DACPF_OFF_CTRL
		|=> current_clamp_en_o == $past(clamp_bit))
		else $error("clamp enable did not follow write");
	a_pwr_off: assert property (
		wr_ok && paddr_i == `DACPF_OFF_PWR && !pu_a_bit
		|=> !amp_output_gate_o[0])
		else $error("channel a stayed on after power off");
	a_autopd_trip: assert property (
		(oc_a_i && !current_clamp_en_o) [*5] |-> !amp_output_gate_o[0])
		else $error("short did not power channel a down");
endmodule

// ### test/dacpf_host.sv
// apb master model standing in for the host controller
`timescale 1ns/10ps
module dacpf_host (
	// clock
	input wire logic clk_i,
	// apb master side
	output logic psel_o = 1'b0,
	output logic penable_o = 1'b0,
	output logic pwrite_o = 1'b0,
	output logic [7:0] paddr_o = 8'h00,
	output logic [31:0] pwdata_o = 32'h0,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	logic [31:0] rdata;
	logic err;
	// setup, then access held until ready is seen at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		while (pready_i !== 1'b1) @(posedge clk_i);
		rdata = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d;
	endtask
endmodule

// ### test/dacpf_top_test.sv
// self-checking bench for the power and fault block
`timescale 1ns/10ps
`include "dacpf_consts.svh"
module dacpf_top_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic supply_ok_i = 1'b1;
	logic oc_a_i = 1'b0;
	logic oc_b_i = 1'b0;
	logic over_temp_i = 1'b0;
	logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, v;
	logic [15:0] dac_a_data_o, dac_b_data_o;
	logic [1:0] amp_output_gate_o, output_ground_clamp_gate_o;
	logic current_clamp_en_o;
	int n_fail = 0;
	int check_count = 0;
	int seed = 32'h8178;
	int cyc = 0;
	int m_pu = 0;
	int m_valid = 0;
	logic [15:0] m_dac[$];
	initial forever #10 clk_i = ~clk_i;
	dacpf_top #(.PU_CYC(8)) dut (.clk_i, .rst_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.supply_ok_i, .oc_a_i, .oc_b_i, .over_temp_i, .dac_a_data_o,
		.dac_b_data_o, .amp_output_gate_o, .output_ground_clamp_gate_o,
		.current_clamp_en_o, .irq_o);
	dacpf_host host (.clk_i, .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
		.prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0);
		chk(host.rdata, e);
	endtask
	task wpwr(input logic [31:0] d);
		host.xfer(1'b1, `DACPF_OFF_PWR, d);
		m_pu = d & 5;
		wt(2);
	endtask
	task gchk;
		logic [31:0] e;
		e = m_valid ? {30'h0, m_pu[2], m_pu[0]} : 32'h0;
		chk({30'h0, amp_output_gate_o}, e);
		chk({30'h0, output_ground_clamp_gate_o}, e ^ 32'h3);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wt(1);
		chk({30'h0, output_ground_clamp_gate_o}, 32'h3);
		chk({31'h0, current_clamp_en_o}, 32'h1);
		rdchk(`DACPF_OFF_PWR, 32'h0);
		rdchk(`DACPF_OFF_CTRL, 32'h4);
		$display("reset test done");
		wpwr(32'h2A5);
		gchk();
		chk({30'h0, amp_output_gate_o}, 32'h0);
		rdchk(`DACPF_OFF_PWR, m_pu);
		wt(9);
		v = $random(seed);
		m_dac.push_back(v[15:0]);
		m_dac.push_back(~v[15:0]);
		host.xfer(1'b1, `DACPF_OFF_DAC_A, v);
		host.xfer(1'b1, `DACPF_OFF_DAC_B, ~v);
		m_valid = 1;
		wt(2);
		chk({16'h0, dac_a_data_o}, {16'h0, m_dac.pop_front()});
		chk({16'h0, dac_b_data_o}, {16'h0, m_dac.pop_front()});
		gchk();
		wpwr(32'h4);
		gchk();
		rdchk(`DACPF_OFF_READY, 32'h2);
		wpwr(32'h5);
		wt(9);
		rdchk(`DACPF_OFF_READY, 32'h3);
		$display("power test done");
		@(posedge clk_i) oc_b_i <= 1'b1;
		wt(5);
		rdchk(`DACPF_OFF_PWR, m_pu | 32'h200);
		gchk();
		rdchk(`DACPF_OFF_IRQ_STAT, 32'h2);
		chk({31'h0, irq_o}, 32'h0);
		host.xfer(1'b1, `DACPF_OFF_IRQ_EN, 32'h2);
		wt(1);
		chk({31'h0, irq_o}, 32'h1);
		@(posedge clk_i) oc_b_i <= 1'b0;
		wt(5);
		rdchk(`DACPF_OFF_PWR, m_pu);
		host.xfer(1'b1, `DACPF_OFF_IRQ_CLR, 32'h2);
		wt(1);
		chk({31'h0, irq_o}, 32'h0);
		$display("clamp test done");
		host.xfer(1'b1, `DACPF_OFF_CTRL, 32'h0);
		wt(1);
		chk({31'h0, current_clamp_en_o}, 32'h0);
		@(posedge clk_i) oc_a_i <= 1'b1;
		wt(5);
		m_pu = m_pu & 4;
		rdchk(`DACPF_OFF_PWR, m_pu | 32'h80);
		gchk();
		@(posedge clk_i) oc_a_i <= 1'b0;
		wt(5);
		wpwr(32'h5);
		wt(9);
		gchk();
		$display("power-down test done");
		@(posedge clk_i) over_temp_i <= 1'b1;
		wt(5);
		rdchk(`DACPF_OFF_PWR, m_pu);
		host.xfer(1'b1, `DACPF_OFF_CTRL, 32'h8);
		wt(5);
		m_pu = 0;
		rdchk(`DACPF_OFF_PWR, 32'h20);
		rdchk(`DACPF_OFF_IRQ_STAT, 32'h5);
		gchk();
		@(posedge clk_i) over_temp_i <= 1'b0;
		wt(5);
		wpwr(32'h5);
		wt(9);
		gchk();
		@(posedge clk_i) supply_ok_i <= 1'b0;
		wt(3);
		chk({30'h0, amp_output_gate_o}, 32'h0);
		$display("thermal test done");
		host.xfer(1'b0, 8'h20, 32'h0);
		chk({31'h0, host.err}, 32'h1);
		chk(host.rdata, 32'h0);
		$display("map test done");
		print_verdict();
	end
endmodule
bind dacpf_top dacpf_top_properties u_props (.clk_i, .rst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .supply_ok_i, .oc_a_i,
	.amp_output_gate_o, .output_ground_clamp_gate_o, .current_clamp_en_o);
